// [udr_pkg.sv]
// Package with register map, reset values and carriers for the divisor block
// Operation
// - The baud divisor is the high divisor byte above the low divisor byte.
// - Power-up loads the high divisor byte with 0x00 and the low with 0x01.
// - The reset pin leaves the divisor bytes alone but resets the rest.
// - On reset the modem status change bits clear, upper bits track inputs.
// - After reset interrupts float or drive low by style; 68 mode IRQ high.
// - Divisor bytes are reached only while line control bit 7 is one.
// - In 16 mode interrupts float when style select, continuous_int and modem bit 3 are all 0.
package udr_pkg;
    localparam int UDR_CHANNELS = 4;
    // Word index of each channel register inside a channel window
    localparam logic [2:0] UDR_IDX_HOLD_DIVLO = 3'h0;
    localparam logic [2:0] UDR_IDX_INTEN_DIVHI = 3'h1;
    localparam logic [2:0] UDR_IDX_INTSRC_FIFO = 3'h2;
    localparam logic [2:0] UDR_IDX_LINE_CTL = 3'h3;
    localparam logic [2:0] UDR_IDX_MODEM_CTL = 3'h4;
    localparam logic [2:0] UDR_IDX_LINE_STAT = 3'h5;
    localparam logic [2:0] UDR_IDX_MODEM_STAT = 3'h6;
    localparam logic [2:0] UDR_IDX_SCRATCH = 3'h7;
    // Global control word: bit 0 requests a power-up style reload
    localparam logic [5:0] UDR_IDX_GLOBAL = 6'h20;
    localparam int UDR_LINE_DIVSEL_BIT = 7;
    localparam int UDR_MODEM_DTR_BIT = 0;
    localparam int UDR_MODEM_RTS_BIT = 1;
    localparam int UDR_MODEM_OUT1_BIT = 2;
    localparam int UDR_MODEM_INTEN_BIT = 3;
    localparam int UDR_MODEM_LOOP_BIT = 4;
    localparam logic [7:0] UDR_DIVHI_RESET = 8'h00;
    localparam logic [7:0] UDR_DIVLO_RESET = 8'h01;
    localparam logic [7:0] UDR_INTEN_RESET = 8'h00;
    localparam logic [7:0] UDR_FIFO_CTL_RESET = 8'h00;
    localparam logic [7:0] UDR_INTSRC_RESET = 8'h01;
    localparam logic [7:0] UDR_LINE_CTL_RESET = 8'h00;
    localparam logic [7:0] UDR_MODEM_CTL_RESET = 8'h00;
    localparam logic [7:0] UDR_LINE_STAT_RESET = 8'h60;
    localparam logic [7:0] UDR_SCRATCH_RESET = 8'hff;
    localparam logic [7:0] UDR_HOLD_RESET = 8'h00;

    // Active-low modem inputs of one channel
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } udr_modem_in_t;

    // Pin outputs of one channel
    typedef struct packed {
        logic tx;
        logic rts_n;
        logic dtr_n;
        logic rx_ready_n;
        logic tx_ready_n;
        logic int_out;
        logic int_oe;
    } udr_pins_t;
endpackage

// [udr_channel.sv]
// One serial channel register set with divisor latches and reset state
`timescale 1ns/1ps
module udr_channel
    import udr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic por_load,
    input wire logic soft_rst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [2:0] idx,
    input wire logic [7:0] wdata,
    input wire udr_modem_in_t modem_in,
    input wire logic mode_68,
    input wire logic interrupt_style_select,
    input wire logic continuous_int,
    output logic [7:0] rdata,
    output logic [15:0] divisor,
    output udr_pins_t pins
);
    logic [7:0] divhi_reg;
    logic [7:0] divlo_reg;
    logic [7:0] inten_reg;
    logic [7:0] fifo_ctl_reg;
    logic [7:0] line_ctl_reg;
    logic [7:0] modem_ctl_reg;
    logic [7:0] line_stat_reg;
    logic [7:0] scratch_reg;
    logic [7:0] tx_hold_reg;
    logic [3:0] delta_reg;
    logic [3:0] prev_reg;
    logic prime_reg;
    logic div_sel;
    logic [3:0] status_now;

    assign div_sel = line_ctl_reg[UDR_LINE_DIVSEL_BIT];
    // High byte above low byte, unsigned
    assign divisor = {divhi_reg, divlo_reg};

    // Divisor latches: no asynchronous reset, only a power-up load
    always_ff @(posedge ref_clk) begin
        if (por_load) begin
            divhi_reg <= UDR_DIVHI_RESET;
            divlo_reg <= UDR_DIVLO_RESET;
        end else if (wr_en && div_sel) begin
            if (idx == UDR_IDX_HOLD_DIVLO) begin
                divlo_reg <= wdata;
            end
            if (idx == UDR_IDX_INTEN_DIVHI) begin
                divhi_reg <= wdata;
            end
        end
    end

    // Normal channel registers, reset by the pin or soft reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            inten_reg <= UDR_INTEN_RESET;
            fifo_ctl_reg <= UDR_FIFO_CTL_RESET;
            line_ctl_reg <= UDR_LINE_CTL_RESET;
            modem_ctl_reg <= UDR_MODEM_CTL_RESET;
            line_stat_reg <= UDR_LINE_STAT_RESET;
            scratch_reg <= UDR_SCRATCH_RESET;
            tx_hold_reg <= UDR_HOLD_RESET;
        end else if (soft_rst) begin
            inten_reg <= UDR_INTEN_RESET;
            fifo_ctl_reg <= UDR_FIFO_CTL_RESET;
            line_ctl_reg <= UDR_LINE_CTL_RESET;
            modem_ctl_reg <= UDR_MODEM_CTL_RESET;
            line_stat_reg <= UDR_LINE_STAT_RESET;
            scratch_reg <= UDR_SCRATCH_RESET;
            tx_hold_reg <= UDR_HOLD_RESET;
        end else if (wr_en) begin
            unique case (idx)
                UDR_IDX_HOLD_DIVLO: if (!div_sel) tx_hold_reg <= wdata;
                UDR_IDX_INTEN_DIVHI: if (!div_sel) inten_reg <= wdata;
                UDR_IDX_INTSRC_FIFO: fifo_ctl_reg <= wdata;
                UDR_IDX_LINE_CTL: line_ctl_reg <= wdata;
                UDR_IDX_MODEM_CTL: modem_ctl_reg <= {3'h0, wdata[4:0]};
                UDR_IDX_LINE_STAT: line_stat_reg <= wdata;
                UDR_IDX_MODEM_STAT: ;
                UDR_IDX_SCRATCH: scratch_reg <= wdata;
            endcase
        end
    end

    // Current modem status, inverted inputs or loopback of modem control
    always_comb begin
        if (modem_ctl_reg[UDR_MODEM_LOOP_BIT]) begin
            status_now = {modem_ctl_reg[UDR_MODEM_INTEN_BIT],
                modem_ctl_reg[UDR_MODEM_OUT1_BIT],
                modem_ctl_reg[UDR_MODEM_DTR_BIT],
                modem_ctl_reg[UDR_MODEM_RTS_BIT]};
        end else begin
            status_now = ~modem_in;
        end
    end

    // Change flags: a change seen in a read cycle still wins over the clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            delta_reg <= 4'h0;
            prev_reg <= 4'h0;
            prime_reg <= 1'b0;
        end else if (soft_rst) begin
            delta_reg <= 4'h0;
            prime_reg <= 1'b0;
        end else begin
            prev_reg <= status_now;
            prime_reg <= 1'b1;
            if (rd_en && idx == UDR_IDX_MODEM_STAT) begin
                delta_reg <= 4'h0;
            end
            if (prime_reg) begin
                delta_reg[0] <= (delta_reg[0] && !(rd_en
                    && idx == UDR_IDX_MODEM_STAT))
                    || (status_now[0] ^ prev_reg[0]);
                delta_reg[1] <= (delta_reg[1] && !(rd_en
                    && idx == UDR_IDX_MODEM_STAT))
                    || (status_now[1] ^ prev_reg[1]);
                delta_reg[2] <= (delta_reg[2] && !(rd_en
                    && idx == UDR_IDX_MODEM_STAT))
                    || (prev_reg[2] && !status_now[2]);
                delta_reg[3] <= (delta_reg[3] && !(rd_en
                    && idx == UDR_IDX_MODEM_STAT))
                    || (status_now[3] ^ prev_reg[3]);
            end
        end
    end

    // Read multiplexer, divisor bytes only while the latch select bit is set
    always_comb begin
        unique case (idx)
            UDR_IDX_HOLD_DIVLO: rdata = div_sel ? divlo_reg
                : UDR_HOLD_RESET;
            UDR_IDX_INTEN_DIVHI: rdata = div_sel ? divhi_reg
                : inten_reg;
            UDR_IDX_INTSRC_FIFO: rdata = UDR_INTSRC_RESET;
            UDR_IDX_LINE_CTL: rdata = line_ctl_reg;
            UDR_IDX_MODEM_CTL: rdata = modem_ctl_reg;
            UDR_IDX_LINE_STAT: rdata = line_stat_reg;
            UDR_IDX_MODEM_STAT: rdata = {status_now, delta_reg};
            UDR_IDX_SCRATCH: rdata = scratch_reg;
        endcase
    end

    // Pin levels; with no character engine the line idles and no interrupt
    always_comb begin
        pins.tx = 1'b1;
        pins.rx_ready_n = 1'b1;
        pins.tx_ready_n = 1'b0;
        pins.rts_n = modem_ctl_reg[UDR_MODEM_LOOP_BIT] ? 1'b1
            : !modem_ctl_reg[UDR_MODEM_RTS_BIT];
        pins.dtr_n = modem_ctl_reg[UDR_MODEM_LOOP_BIT] ? 1'b1
            : !modem_ctl_reg[UDR_MODEM_DTR_BIT];
        if (mode_68) begin
            pins.int_out = 1'b1;
            pins.int_oe = 1'b1;
        end else begin
            pins.int_out = 1'b0;
            pins.int_oe = continuous_int || interrupt_style_select
                || modem_ctl_reg[UDR_MODEM_INTEN_BIT];
        end
    end
endmodule

// [udr_top.sv]
// Avalon-MM slave holding four channels of divisor and reset-state logic
`timescale 1ns/1ps
module udr_top
    import udr_pkg::*;
#(
    parameter int CHANNELS = UDR_CHANNELS
)(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire udr_modem_in_t [CHANNELS-1:0] modem_in,
    input wire logic mode_68,
    input wire logic interrupt_style_select,
    input wire logic continuous_int,
    output logic [CHANNELS-1:0][15:0] divisor,
    output udr_pins_t [CHANNELS-1:0] pins
);
    logic [5:0] word;
    logic acc_reg;
    logic por_done_reg;
    logic por_load;
    logic soft_rst_reg;
    logic [CHANNELS-1:0][7:0] ch_rdata;
    logic [CHANNELS-1:0][15:0] ch_div;
    udr_pins_t [CHANNELS-1:0] ch_pins;

    assign word = address[7:2];
    // First clock after power-up loads the divisors once
    assign por_load = !por_done_reg;

    // Power-up marker; a soft reload also re-arms it
    always_ff @(posedge ref_clk) begin
        if (soft_rst_reg) begin
            por_done_reg <= 1'b0;
        end else begin
            por_done_reg <= 1'b1;
        end
    end

    // One wait cycle per access: the request is taken on the second edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            acc_reg <= 1'b0;
            waitrequest <= 1'b1;
        end else begin
            acc_reg <= (read || write) && !acc_reg;
            waitrequest <= !((read || write) && !acc_reg);
        end
    end

    // Global control write pulses a reload of all channels
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= acc_reg && write && byteenable[0]
                && word == UDR_IDX_GLOBAL && writedata[0];
        end
    end

    // Channel instances, each a window of eight words
    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        udr_channel u_ch (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .por_load(por_load),
            .soft_rst(soft_rst_reg),
            .wr_en(acc_reg && write && byteenable[0] && !word[5]
                && word[4:3] == 2'(c)),
            .rd_en(acc_reg && read && !word[5] && word[4:3] == 2'(c)),
            .idx(word[2:0]),
            .wdata(writedata[7:0]),
            .modem_in(modem_in[c]),
            .mode_68(mode_68),
            .interrupt_style_select(interrupt_style_select),
            .continuous_int(continuous_int),
            .rdata(ch_rdata[c]),
            .divisor(ch_div[c]),
            .pins(ch_pins[c])
        );
    end

    // Read data registered in the wait cycle; unmapped words read zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !acc_reg) begin
            if (!word[5] && int'(word[4:3]) < CHANNELS) begin
                readdata <= {24'h00_0000, ch_rdata[word[4:3]]};
            end else begin
                readdata <= 32'h0000_0000;
            end
        end
    end

    // Registered outputs; pin levels hold their reset values under nrst
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < CHANNELS; c++) begin
                pins[c] <= '{tx: 1'b1, rts_n: 1'b1, dtr_n: 1'b1,
                    rx_ready_n: 1'b1, tx_ready_n: 1'b0, int_out: 1'b0,
                    int_oe: 1'b0};
            end
        end else begin
            pins <= ch_pins;
        end
    end

    // Divisor copy is not touched by the reset pin, like the latches
    always_ff @(posedge ref_clk) begin
        divisor <= ch_div;
    end
endmodule

// [udr_chk.sv]
// Checker for bus handshake, divisor update and pin reset state
`timescale 1ns/1ps
module udr_chk
    import udr_pkg::*;
#(
    parameter int CHANNELS = UDR_CHANNELS
)(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic mode_68,
    input wire logic interrupt_style_select,
    input wire logic continuous_int,
    input wire logic [CHANNELS-1:0][15:0] divisor,
    input wire udr_pins_t [CHANNELS-1:0] pins
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Request start, single answer cycle, interrupt drive condition
    sequence s_req;
        $rose(read || write);
    endsequence
    sequence s_ack;
        !waitrequest ##1 waitrequest;
    endsequence
    sequence s_int_sel;
        !mode_68 && (interrupt_style_select || continuous_int);
    endsequence
    property p_answer;
        s_req |=> s_ack;
    endproperty
    property p_no_spurious;
        !waitrequest |-> $past(read || write);
    endproperty
    property p_unmapped;
        read && !waitrequest && address[7:2] > 6'h20 |-> readdata == 32'h0;
    endproperty
    property p_div_cause;
        $changed(divisor) && $past(nrst, 2) |->
            $past(write && !waitrequest, 2)
            || $past(write && !waitrequest
            && address[7:2] == UDR_IDX_GLOBAL, 4);
    endproperty
    property p_idle_rst;
        $rose(nrst) |-> pins[0].tx && pins[0].rts_n && pins[0].dtr_n
            && pins[0].rx_ready_n && !pins[0].tx_ready_n && !pins[0].int_oe;
    endproperty
    property p_int_drive;
        s_int_sel ##1 s_int_sel |-> pins[0].int_oe && !pins[0].int_out;
    endproperty
    property p_irq_68;
        mode_68 ##1 mode_68 |-> pins[0].int_oe && pins[0].int_out;
    endproperty
    property p_dtr_cause;
        $fell(pins[0].dtr_n) |-> $past(write) || $past(write, 2);
    endproperty
    a_answer: assert property (p_answer)
        else $error("request not answered after one wait cycle");
    a_no_spurious: assert property (p_no_spurious)
        else $error("waitrequest low without a request");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero data");
    a_div_cause: assert property (p_div_cause)
        else $error("divisor changed without a write");
    a_idle_rst: assert property (p_idle_rst)
        else $error("pins not idle at reset release");
    a_int_drive: assert property (p_int_drive)
        else $error("interrupt output not driven low");
    a_irq_68: assert property (p_irq_68)
        else $error("interrupt request not high in 68 mode");
    a_dtr_cause: assert property (p_dtr_cause)
        else $error("terminal ready fell without a write");
endmodule
bind udr_top udr_chk #(.CHANNELS(CHANNELS)) u_chk (.ref_clk, .nrst,
    .address, .read, .write, .readdata, .waitrequest, .mode_68,
    .interrupt_style_select, .continuous_int, .divisor, .pins);

// [udr_host.sv]
// Host model issuing register bus transfers
`timescale 1ns/1ps
module udr_host (
    input wire logic ref_clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable
);
    initial {address, read, write, writedata, byteenable} = '0;
    // Hold the request until waitrequest is sampled low, then release
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] q);
        int n;
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, d};
        byteenable <= 4'h1;
        n = 0;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                tb_top.failures++;
                tb_top.end_of_test();
            end
            @(posedge ref_clk);
        end
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the divisor and reset-state register block
`timescale 1ns/1ps
module tb_top;
    import udr_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, mode_68 = 1'b0, sel = 1'b0;
    logic cont = 1'b0, read, write, waitrequest;
    logic [7:0] address, q;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    udr_modem_in_t [3:0] modem_in = {4{4'b1010}};
    logic [3:0][15:0] divisor;
    udr_pins_t [3:0] pins;
    logic [2:0] ctl [3] = '{3'b001, 3'b010, 3'b100};
    int failures = 0, compares = 0;
    initial forever #5 ref_clk = ~ref_clk;
    udr_top #(.CHANNELS(4)) u_dut (.ref_clk, .nrst, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest,
        .modem_in, .mode_68, .interrupt_style_select(sel),
        .continuous_int(cont), .divisor, .pins);
    udr_host u_host (.ref_clk, .waitrequest, .readdata, .address, .read,
        .write, .writedata, .byteenable);
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input int c, input logic [2:0] i, input logic [7:0] d);
        u_host.xfer(1'b1, {1'b0, c[1:0], i, 2'b00}, d, q);
    endtask
    task automatic rd(input int c, input logic [2:0] i, input logic [7:0] e);
        u_host.xfer(1'b0, {1'b0, c[1:0], i, 2'b00}, 8'h00, q);
        check({8'h0, q}, {8'h0, e});
    endtask
    task automatic defaults(input int c);
        rd(c, 1, 8'h00);
        rd(c, 2, 8'h01);
        rd(c, 3, 8'h00);
        rd(c, 4, 8'h00);
        rd(c, 5, 8'h60);
        rd(c, 6, 8'h50);
        rd(c, 7, 8'hff);
    endtask
    task automatic pulse_reset();
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        u_host.xfer(1'b1, 8'h80, 8'h01, q);
        for (int c = 0; c < 4; c++) begin
            defaults(c);
            wr(c, 3, 8'h80);
            rd(c, 0, 8'h01);
            rd(c, 1, 8'h00);
            check(divisor[c], 16'h0001);
            wr(c, 0, 8'h30 + c[7:0]);
            wr(c, 1, 8'h12);
            @(posedge ref_clk);
            check(divisor[c], 16'h1230 + c[15:0]);
            wr(c, 3, 8'h03);
            wr(c, 1, 8'h05);
            rd(c, 1, 8'h05);
            check(divisor[c], 16'h1230 + c[15:0]);
        end
        u_host.xfer(1'b0, 8'h84, 8'h00, q);
        check({8'h0, q}, 16'h0000);
        $display("test defaults and divisor done");
        pulse_reset();
        for (int c = 0; c < 4; c++) begin
            check(divisor[c], 16'h1230 + c[15:0]);
            defaults(c);
        end
        check({9'h0, pins[0]}, 16'h0078);
        $display("test reset pin done");
        modem_in[0] <= 4'b1011;
        repeat (2) @(posedge ref_clk);
        rd(0, 6, 8'h41);
        pulse_reset();
        rd(0, 6, 8'h40);
        $display("test modem status done");
        wr(0, 4, 8'h0b);
        @(posedge ref_clk);
        check({9'h0, pins[0]}, 16'h0049);
        wr(0, 4, 8'h00);
        for (int k = 0; k < 3; k++) begin
            {mode_68, cont, sel} <= ctl[k];
            repeat (3) @(posedge ref_clk);
            check({14'h0, pins[0].int_out, pins[0].int_oe},
                {14'h0, k == 2, 1'b1});
        end
        $display("test interrupt outputs done");
        end_of_test();
    end
endmodule
